// [logic/pll_clock_module.sv]
`timescale 1ns/1ps
module pll_clock_module #(
    parameter int LOCK_CYCLES = pll_clock_pkg::LOCK_OSC_CYCLES,
    parameter int MISSING_TIMEOUT = pll_clock_pkg::MISSING_TIMEOUT_CYCLES
) (
    input wire logic clk,
    input wire logic resetn,
    input wire logic osc_input_pin,
    input wire logic ext_clock_input_pin,
    input wire logic external_source_select,
    input wire logic external_reset_pin_n,
    input wire logic watchdog_reset,
    input wire logic protected_write_enable,
    input wire logic ratio_write,
    input wire logic [pll_clock_pkg::RATIO_W-1:0] ratio_wdata,
    input wire logic status_write,
    input wire logic [pll_clock_pkg::POST_DIVIDER_SELECT_W-1:0] post_divider_select_wdata,
    input wire logic pll_disable_wdata,
    input wire logic missing_clock_clear,
    output logic [pll_clock_pkg::RATIO_W-1:0] pll_ratio_reg,
    output logic [pll_clock_pkg::POST_DIVIDER_SELECT_W-1:0] post_divider_select,
    output logic pll_disable_bit,
    output logic lock_done_flag,
    output logic missing_clock_flag,
    output pll_clock_pkg::clock_mode_t clock_mode,
    output logic [pll_clock_pkg::RATIO_W-1:0] cpu_clock_multiplier,
    output logic [2:0] cpu_clock_divider,
    output logic limp_active,
    output logic device_reset_out,
    output logic watchdog_count_enable
);
    import pll_clock_pkg::*;

    localparam int LCW = $clog2(LOCK_CYCLES);
    localparam int RCW = $clog2(RESET_PULSE_CYCLES + 1);

    // ----------------------------------------------------------------
    // Pin synchronisers
    // ----------------------------------------------------------------
    logic [1:0] osc_sync;
    logic [1:0] ext_sync;
    logic [1:0] rst_sync;

    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            osc_sync <= 2'h0;
            ext_sync <= 2'h0;
            rst_sync <= 2'h0;
        end else begin
            osc_sync <= {osc_sync[0], osc_input_pin};
            ext_sync <= {ext_sync[0], ext_clock_input_pin};
            rst_sync <= {rst_sync[0], external_reset_pin_n};
        end
    end

    logic src_level;
    logic reg_reset;
    logic osc_edge;
    logic clock_missing;
    logic osc_seen;

    // Oscillator source: crystal input or external clock pin
    assign src_level = external_source_select ? ext_sync[1] : osc_sync[1];
    // Besides resetn, the reset pin and watchdog reset restore ratio and status
    assign reg_reset = ~rst_sync[1] | watchdog_reset;

    osc_activity_monitor #(
        .TIMEOUT(MISSING_TIMEOUT)
    ) u_monitor (
        .clk(clk),
        .resetn(resetn),
        .osc_level(src_level),
        .osc_edge(osc_edge),
        .clock_missing(clock_missing),
        .osc_seen(osc_seen)
    );

    // ----------------------------------------------------------------
    // Ratio and status registers
    // ----------------------------------------------------------------
    logic ratio_accept;
    logic missing_event;
    logic missing_q;
    logic [RATIO_W-1:0] next_ratio;
    logic [POST_DIVIDER_SELECT_W-1:0] next_post_divider_select;
    logic next_disable;
    logic next_missing_flag;

    assign ratio_accept = ratio_write & protected_write_enable & (ratio_wdata <= RATIO_MAX);
    assign missing_event = clock_missing & ~missing_q & osc_seen;

    // Register writes; a failure event wins over a software clear
    always_comb begin
        next_ratio = pll_ratio_reg;
        next_post_divider_select = post_divider_select;
        next_disable = pll_disable_bit;
        next_missing_flag = missing_clock_flag;
        if (reg_reset) begin
            next_ratio = RATIO_RESET;
            next_post_divider_select = POST_DIVIDER_SELECT_RESET;
            next_disable = PLL_DISABLE_RESET;
            next_missing_flag = 1'b0;
        end else begin
            if (ratio_accept) begin
                next_ratio = ratio_wdata;
            end
            if (status_write && protected_write_enable) begin
                next_post_divider_select = post_divider_select_wdata;
                next_disable = pll_disable_wdata;
            end
            if (missing_clock_clear) begin
                next_missing_flag = 1'b0;
            end
            if (missing_event) begin
                next_missing_flag = 1'b1;
            end
        end
    end

    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            pll_ratio_reg <= RATIO_RESET;
            post_divider_select <= POST_DIVIDER_SELECT_RESET;
            pll_disable_bit <= PLL_DISABLE_RESET;
            missing_clock_flag <= 1'b0;
            missing_q <= 1'b0;
        end else begin
            pll_ratio_reg <= next_ratio;
            post_divider_select <= next_post_divider_select;
            pll_disable_bit <= next_disable;
            missing_clock_flag <= next_missing_flag;
            missing_q <= clock_missing;
        end
    end

    // ----------------------------------------------------------------
    // Relock sequencer
    // ----------------------------------------------------------------
    lock_state_t lock_state;
    lock_state_t next_lock_state;
    logic [LCW-1:0] lock_count;
    logic [LCW-1:0] next_lock_count;
    logic next_lock_flag;

    // Counts oscillator edges after each accepted ratio write
    always_comb begin
        next_lock_state = lock_state;
        next_lock_count = lock_count;
        next_lock_flag = lock_done_flag;
        if (reg_reset) begin
            next_lock_state = LOCK_STABLE;
            next_lock_count = '0;
            next_lock_flag = 1'b0;
        end else if (ratio_accept) begin
            next_lock_state = LOCK_RELOCKING;
            next_lock_count = '0;
            next_lock_flag = 1'b0;
        end else begin
            case (lock_state)
                LOCK_RELOCKING: begin
                    if (osc_edge) begin
                        if (lock_count == LCW'(LOCK_CYCLES - 1)) begin
                            next_lock_state = LOCK_STABLE;
                            next_lock_flag = 1'b1;
                        end else begin
                            next_lock_count = lock_count + LCW'(1);
                        end
                    end
                end
                default: begin
                    next_lock_count = '0;
                end
            endcase
        end
    end

    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            lock_state <= LOCK_STABLE;
            lock_count <= '0;
            lock_done_flag <= 1'b0;
        end else begin
            lock_state <= next_lock_state;
            lock_count <= next_lock_count;
            lock_done_flag <= next_lock_flag;
        end
    end

    // ----------------------------------------------------------------
    // Clock selection and failure handling
    // ----------------------------------------------------------------
    clock_mode_t next_mode;
    logic [RATIO_W-1:0] next_mult;
    logic [2:0] next_div;
    logic [RCW-1:0] rst_count;
    logic [RCW-1:0] next_rst_count;
    logic limp_cond;

    assign limp_cond = clock_missing & osc_seen & ~pll_disable_bit;

    // Mode, multiplier, divider and reset pulse
    always_comb begin
        next_mult = RATIO_UNITY;
        if (pll_disable_bit) begin
            next_mode = MODE_OFF;
        end else if (limp_cond) begin
            next_mode = MODE_LIMP;
        end else if (pll_ratio_reg == RATIO_BYPASS || lock_state == LOCK_RELOCKING) begin
            next_mode = MODE_BYPASS;
        end else begin
            next_mode = MODE_ENABLE;
            next_mult = pll_ratio_reg;
        end
        if (post_divider_select == POST_DIVIDER_SELECT_DIV1 && next_mode != MODE_ENABLE) begin
            next_div = DIV_BY_1;
        end else if (post_divider_select >= POST_DIVIDER_SELECT_DIV2) begin
            next_div = DIV_BY_2;
        end else begin
            next_div = DIV_BY_4;
        end
        next_rst_count = rst_count;
        if (missing_event) begin
            next_rst_count = RCW'(RESET_PULSE_CYCLES);
        end else if (rst_count != '0) begin
            next_rst_count = rst_count - RCW'(1);
        end
    end

    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            clock_mode <= MODE_BYPASS;
            cpu_clock_multiplier <= RATIO_UNITY;
            cpu_clock_divider <= DIV_BY_4;
            limp_active <= 1'b0;
            rst_count <= '0;
            device_reset_out <= 1'b0;
            watchdog_count_enable <= 1'b0;
        end else begin
            clock_mode <= next_mode;
            cpu_clock_multiplier <= next_mult;
            cpu_clock_divider <= next_div;
            limp_active <= limp_cond;
            rst_count <= next_rst_count;
            device_reset_out <= (next_rst_count != '0);
            watchdog_count_enable <= ~clock_missing & osc_seen;
        end
    end

    // ----------------------------------------------------------------
    // Checks
    // ----------------------------------------------------------------
    property p_ratio_protect;
        @(posedge clk) disable iff (!resetn || reg_reset)
        (ratio_write && !protected_write_enable) |=> $stable(pll_ratio_reg);
    endproperty
    a_ratio_protect: assert property (p_ratio_protect)
        else $error("unprotected ratio write took effect");

    property p_ratio_store;
        @(posedge clk) disable iff (!resetn || reg_reset)
        ratio_accept |=> (pll_ratio_reg == $past(ratio_wdata));
    endproperty
    a_ratio_store: assert property (p_ratio_store)
        else $error("accepted ratio not stored");

    property p_write_bypass;
        @(posedge clk) disable iff (!resetn || reg_reset)
        ratio_accept |=> !lock_done_flag ##1 (clock_mode != MODE_ENABLE);
    endproperty
    a_write_bypass: assert property (p_write_bypass)
        else $error("ratio write did not force bypass and clear lock");

    property p_div_slow;
        @(posedge clk) disable iff (!resetn)
        (post_divider_select < POST_DIVIDER_SELECT_DIV2) |=> (cpu_clock_divider == DIV_BY_4);
    endproperty
    a_div_slow: assert property (p_div_slow)
        else $error("divider select 0 or 1 not divide by 4");

    property p_enable_no_div1;
        @(posedge clk) disable iff (!resetn)
        (clock_mode == MODE_ENABLE) |-> (cpu_clock_divider != DIV_BY_1);
    endproperty
    a_enable_no_div1: assert property (p_enable_no_div1)
        else $error("divide by 1 while multiplying");

    property p_off_mode;
        @(posedge clk) disable iff (!resetn)
        pll_disable_bit |=> (clock_mode == MODE_OFF && cpu_clock_multiplier == RATIO_UNITY);
    endproperty
    a_off_mode: assert property (p_off_mode)
        else $error("disable bit did not turn the PLL off");

    property p_zero_bypass;
        @(posedge clk) disable iff (!resetn)
        (pll_ratio_reg == RATIO_BYPASS && !pll_disable_bit && !limp_cond)
            |=> (clock_mode == MODE_BYPASS);
    endproperty
    a_zero_bypass: assert property (p_zero_bypass)
        else $error("zero ratio not in bypass");

    property p_limp;
        @(posedge clk) disable iff (!resetn)
        limp_cond |=> (clock_mode == MODE_LIMP && limp_active);
    endproperty
    a_limp: assert property (p_limp)
        else $error("missing clock did not select limp clock");

    property p_no_early_limp;
        @(posedge clk) disable iff (!resetn)
        !osc_seen |=> !limp_active;
    endproperty
    a_no_early_limp: assert property (p_no_early_limp)
        else $error("limp before clock ever seen");

    property p_wd_stop;
        @(posedge clk) disable iff (!resetn)
        clock_missing |=> !watchdog_count_enable;
    endproperty
    a_wd_stop: assert property (p_wd_stop)
        else $error("watchdog kept counting without clock");

    property p_fail_reset;
        @(posedge clk) disable iff (!resetn || reg_reset)
        missing_event |=> (missing_clock_flag && device_reset_out)[*8];
    endproperty
    a_fail_reset: assert property (p_fail_reset)
        else $error("clock failure did not flag and reset");

    property p_reg_reset;
        @(posedge clk) disable iff (!resetn)
        reg_reset |=> (pll_ratio_reg == RATIO_RESET && post_divider_select == POST_DIVIDER_SELECT_RESET
            && !lock_done_flag && !missing_clock_flag);
    endproperty
    a_reg_reset: assert property (p_reg_reset)
        else $error("reset pin or watchdog did not restore defaults");

    c_lock: cover property (@(posedge clk) disable iff (!resetn) $rose(lock_done_flag));
    c_enable: cover property (@(posedge clk) disable iff (!resetn) clock_mode == MODE_ENABLE);
    c_limp: cover property (@(posedge clk) disable iff (!resetn) $rose(limp_active));
    c_off: cover property (@(posedge clk) disable iff (!resetn) clock_mode == MODE_OFF);

endmodule : pll_clock_module

// [logic/pll_clock_pkg.sv]
package pll_clock_pkg;

    // ----------------------------------------------------------------
    // Field widths and reset values
    // ----------------------------------------------------------------
    localparam int RATIO_W = 4;
    localparam int POST_DIVIDER_SELECT_W = 2;
    localparam logic [3:0] RATIO_RESET = 4'h0;
    localparam logic [3:0] RATIO_BYPASS = 4'h0;
    localparam logic [3:0] RATIO_MAX = 4'ha;
    localparam logic [3:0] RATIO_UNITY = 4'h1;
    localparam logic [1:0] POST_DIVIDER_SELECT_RESET = 2'h0;
    localparam logic [1:0] POST_DIVIDER_SELECT_DIV2 = 2'h2;
    localparam logic [1:0] POST_DIVIDER_SELECT_DIV1 = 2'h3;
    localparam logic PLL_DISABLE_RESET = 1'b0;

    // ----------------------------------------------------------------
    // Effective divide factors shown on the divider output
    // ----------------------------------------------------------------
    localparam logic [2:0] DIV_BY_4 = 3'h4;
    localparam logic [2:0] DIV_BY_2 = 3'h2;
    localparam logic [2:0] DIV_BY_1 = 3'h1;

    // ----------------------------------------------------------------
    // Timing
    // ----------------------------------------------------------------
    localparam int CLK_PERIOD_NS = 40;
    localparam int LOCK_OSC_CYCLES = 131072;
    localparam int MISSING_TIMEOUT_NS = 2000;
    localparam int MISSING_TIMEOUT_CYCLES = MISSING_TIMEOUT_NS / CLK_PERIOD_NS;
    localparam int RESET_PULSE_CYCLES = 16;

    // ----------------------------------------------------------------
    // Types
    // ----------------------------------------------------------------
    typedef enum logic [1:0] {MODE_OFF, MODE_BYPASS, MODE_ENABLE, MODE_LIMP} clock_mode_t;
    typedef enum logic {LOCK_STABLE, LOCK_RELOCKING} lock_state_t;

endpackage : pll_clock_pkg

// [logic/osc_activity_monitor.sv]
`timescale 1ns/1ps
module osc_activity_monitor #(
    parameter int TIMEOUT = pll_clock_pkg::MISSING_TIMEOUT_CYCLES
) (
    input wire logic clk,
    input wire logic resetn,
    input wire logic osc_level,
    output logic osc_edge,
    output logic clock_missing,
    output logic osc_seen
);
    import pll_clock_pkg::*;

    localparam int CW = $clog2(TIMEOUT + 1);

    logic last_level;
    logic [CW-1:0] idle_count;
    logic next_osc_edge;
    logic next_clock_missing;
    logic next_osc_seen;
    logic [CW-1:0] next_idle_count;

    // Edge detection and idle timeout
    always_comb begin
        next_osc_edge = osc_level & ~last_level;
        next_osc_seen = osc_seen | next_osc_edge;
        next_idle_count = idle_count;
        next_clock_missing = clock_missing;
        if (next_osc_edge) begin
            next_idle_count = '0;
            next_clock_missing = 1'b0;
        end else if (idle_count == CW'(TIMEOUT)) begin
            next_clock_missing = 1'b1;
        end else begin
            next_idle_count = idle_count + CW'(1);
        end
    end

    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            last_level <= 1'b0;
            osc_edge <= 1'b0;
            osc_seen <= 1'b0;
            idle_count <= '0;
            clock_missing <= 1'b0;
        end else begin
            last_level <= osc_level;
            osc_edge <= next_osc_edge;
            osc_seen <= next_osc_seen;
            idle_count <= next_idle_count;
            clock_missing <= next_clock_missing;
        end
    end

    // ----------------------------------------------------------------
    // Checks
    // ----------------------------------------------------------------
    property p_edge_clears_missing;
        @(posedge clk) disable iff (!resetn)
        (osc_level && !last_level) |=> (!clock_missing && osc_edge);
    endproperty
    a_edge_clears_missing: assert property (p_edge_clears_missing)
        else $error("missing flag not cleared by oscillator edge");

    property p_timeout_sets_missing;
        @(posedge clk) disable iff (!resetn)
        (idle_count == CW'(TIMEOUT) && !(osc_level && !last_level)) |=> clock_missing;
    endproperty
    a_timeout_sets_missing: assert property (p_timeout_sets_missing)
        else $error("idle timeout did not raise missing");

endmodule : osc_activity_monitor

// [verification/testbench.sv]
`timescale 1ns/1ps
module testbench;
    import pll_clock_pkg::*;

    // ----------------------------------------------------------------
    // Signals and device under test
    // ----------------------------------------------------------------
    logic clk, resetn, osc_input_pin, ext_clock_input_pin, external_source_select;
    logic external_reset_pin_n, watchdog_reset, protected_write_enable, ratio_write;
    logic [3:0] ratio_wdata;
    logic status_write, pll_disable_wdata, missing_clock_clear;
    logic [1:0] post_divider_select_wdata;
    logic [3:0] pll_ratio_reg, cpu_clock_multiplier;
    logic [1:0] post_divider_select;
    logic [2:0] cpu_clock_divider;
    logic pll_disable_bit, lock_done_flag, missing_clock_flag, limp_active;
    logic device_reset_out, watchdog_count_enable;
    clock_mode_t clock_mode;
    logic osc_on, ext_on;
    int bad_count, num_checks;

    pll_clock_module #(.LOCK_CYCLES(8), .MISSING_TIMEOUT(8)) pll_clock_module_i (
        .clk(clk), .resetn(resetn), .osc_input_pin(osc_input_pin),
        .ext_clock_input_pin(ext_clock_input_pin), .external_source_select(external_source_select),
        .external_reset_pin_n(external_reset_pin_n), .watchdog_reset(watchdog_reset),
        .protected_write_enable(protected_write_enable), .ratio_write(ratio_write),
        .ratio_wdata(ratio_wdata), .status_write(status_write), .post_divider_select_wdata(post_divider_select_wdata),
        .pll_disable_wdata(pll_disable_wdata), .missing_clock_clear(missing_clock_clear),
        .pll_ratio_reg(pll_ratio_reg), .post_divider_select(post_divider_select),
        .pll_disable_bit(pll_disable_bit), .lock_done_flag(lock_done_flag),
        .missing_clock_flag(missing_clock_flag), .clock_mode(clock_mode),
        .cpu_clock_multiplier(cpu_clock_multiplier), .cpu_clock_divider(cpu_clock_divider),
        .limp_active(limp_active), .device_reset_out(device_reset_out),
        .watchdog_count_enable(watchdog_count_enable));

    // ----------------------------------------------------------------
    // Clock, oscillator pins and watchdog
    // ----------------------------------------------------------------
    initial begin
        clk = 1'b0;
        forever #20 clk = ~clk;
    end

    // Oscillator pins toggle every two cycles while running, hold level when stopped
    initial begin
        forever begin
            repeat (2) @(negedge clk);
            if (osc_on) osc_input_pin = ~osc_input_pin;
            if (ext_on) ext_clock_input_pin = ~ext_clock_input_pin;
        end
    end

    // Cuts a hung run short
    initial begin
        repeat (20000) @(posedge clk);
        bad_count++;
        $display("CHECK FAILED run_time expected done seen timeout");
        tally_and_finish();
    end

    // ----------------------------------------------------------------
    // Shared tasks
    // ----------------------------------------------------------------
    task automatic check_val(input string what, input logic [3:0] exp, input logic [3:0] got);
        num_checks++;
        if (got !== exp) begin
            bad_count++;
            $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
        end
    endtask : check_val

    task automatic check_bit(input string what, input logic exp, input logic got);
        num_checks++;
        if (got !== exp) begin
            bad_count++;
            $display("CHECK FAILED %s expected %b seen %b", what, exp, got);
        end
    endtask : check_bit

    task automatic write_ratio(input logic pe, input logic [3:0] v);
        @(negedge clk);
        protected_write_enable = pe;
        ratio_wdata = v;
        ratio_write = 1'b1;
        @(negedge clk);
        ratio_write = 1'b0;
        protected_write_enable = 1'b0;
        repeat (2) @(negedge clk);
    endtask : write_ratio

    task automatic write_status(input logic pe, input logic [1:0] d, input logic off);
        @(negedge clk);
        protected_write_enable = pe;
        post_divider_select_wdata = d;
        pll_disable_wdata = off;
        status_write = 1'b1;
        @(negedge clk);
        status_write = 1'b0;
        protected_write_enable = 1'b0;
        repeat (2) @(negedge clk);
    endtask : write_status

    task automatic wait_lock();
        int i;
        for (i = 0; i < 300 && lock_done_flag !== 1'b1; i++) @(negedge clk);
        check_bit("lock_done_flag", 1'b1, lock_done_flag);
        repeat (2) @(negedge clk);
    endtask : wait_lock

    task automatic tally_and_finish();
        $display("checks %0d mismatches %0d", num_checks, bad_count);
        if (bad_count == 0 && num_checks > 0) $display("ALL CHECKS OK");
        else $display("CHECKS NOT OK");
        $finish;
    endtask : tally_and_finish

    // ----------------------------------------------------------------
    // Scenarios
    // ----------------------------------------------------------------
    task automatic t_refused();
        write_ratio(1'b0, 4'h5);
        check_val("ratio unprotected", 4'h0, pll_ratio_reg);
        write_ratio(1'b1, 4'hb);
        check_val("ratio reserved", 4'h0, pll_ratio_reg);
        write_status(1'b0, 2'h2, 1'b0);
        check_val("post_divider_select unprotected", 4'h0, {2'h0, post_divider_select});
    endtask : t_refused

    task automatic t_post_divider_select_bypass();
        logic [2:0] exp_div [4] = '{3'h4, 3'h4, 3'h2, 3'h1};
        for (int i = 0; i < 4; i++) begin
            write_status(1'b1, i[1:0], 1'b0);
            check_val("bypass divider", {1'b0, exp_div[i]}, {1'b0, cpu_clock_divider});
        end
        write_status(1'b1, 2'h0, 1'b0);
    endtask : t_post_divider_select_bypass

    task automatic t_ratio_lock();
        write_ratio(1'b1, 4'h3);
        check_val("ratio", 4'h3, pll_ratio_reg);
        check_bit("lock after write", 1'b0, lock_done_flag);
        check_val("mode relock", {2'h0, MODE_BYPASS}, {2'h0, clock_mode});
        wait_lock();
        check_val("mode locked", {2'h0, MODE_ENABLE}, {2'h0, clock_mode});
        check_val("multiplier", 4'h3, cpu_clock_multiplier);
        check_val("divider /4", 4'h4, {1'b0, cpu_clock_divider});
        write_status(1'b1, 2'h2, 1'b0);
        check_val("divider /2", 4'h2, {1'b0, cpu_clock_divider});
        write_status(1'b1, 2'h0, 1'b0);
        write_ratio(1'b1, 4'ha);
        check_val("mode relock max", {2'h0, MODE_BYPASS}, {2'h0, clock_mode});
        check_bit("lock cleared by write", 1'b0, lock_done_flag);
        wait_lock();
        check_val("multiplier max", 4'ha, cpu_clock_multiplier);
        write_ratio(1'b1, 4'h0);
        wait_lock();
        check_val("mode zero ratio", {2'h0, MODE_BYPASS}, {2'h0, clock_mode});
    endtask : t_ratio_lock

    task automatic t_pll_off();
        write_status(1'b1, 2'h3, 1'b1);
        check_bit("disable bit", 1'b1, pll_disable_bit);
        check_val("mode off", {2'h0, MODE_OFF}, {2'h0, clock_mode});
        check_val("divider off", 4'h1, {1'b0, cpu_clock_divider});
        write_status(1'b1, 2'h0, 1'b0);
    endtask : t_pll_off

    task automatic t_restores();
        write_ratio(1'b1, 4'h5);
        wait_lock();
        write_status(1'b1, 2'h2, 1'b0);
        @(negedge clk);
        watchdog_reset = 1'b1;
        @(negedge clk);
        watchdog_reset = 1'b0;
        @(negedge clk);
        check_val("ratio wd reset", 4'h0, pll_ratio_reg);
        check_val("post_divider_select wd reset", 4'h0, {2'h0, post_divider_select});
        write_ratio(1'b1, 4'h7);
        external_reset_pin_n = 1'b0;
        repeat (4) @(negedge clk);
        external_reset_pin_n = 1'b1;
        repeat (4) @(negedge clk);
        check_val("ratio pin reset", 4'h0, pll_ratio_reg);
    endtask : t_restores

    task automatic t_ext_source();
        external_source_select = 1'b1;
        ext_on = 1'b1;
        osc_on = 1'b0;
        repeat (40) @(negedge clk);
        check_bit("missing on ext source", 1'b0, missing_clock_flag);
        check_bit("wd count ext source", 1'b1, watchdog_count_enable);
        osc_on = 1'b1;
        external_source_select = 1'b0;
        repeat (8) @(negedge clk);
        ext_on = 1'b0;
    endtask : t_ext_source

    task automatic t_missing();
        int i;
        write_ratio(1'b1, 4'h6);
        wait_lock();
        osc_on = 1'b0;
        for (i = 0; i < 60 && missing_clock_flag !== 1'b1; i++) @(negedge clk);
        repeat (2) @(negedge clk);
        check_bit("device reset", 1'b1, device_reset_out);
        check_bit("limp", 1'b1, limp_active);
        check_val("mode limp", {2'h0, MODE_LIMP}, {2'h0, clock_mode});
        check_bit("wd count stopped", 1'b0, watchdog_count_enable);
        check_val("ratio kept", 4'h6, pll_ratio_reg);
        repeat (20) @(negedge clk);
        check_bit("missing flag held", 1'b1, missing_clock_flag);
        check_bit("device reset ended", 1'b0, device_reset_out);
        osc_on = 1'b1;
        repeat (8) @(negedge clk);
        missing_clock_clear = 1'b1;
        @(negedge clk);
        missing_clock_clear = 1'b0;
        @(negedge clk);
        check_bit("missing flag cleared", 1'b0, missing_clock_flag);
    endtask : t_missing

    // ----------------------------------------------------------------
    // Main sequence
    // ----------------------------------------------------------------
    initial begin
        {resetn, osc_input_pin, ext_clock_input_pin, external_source_select} = 4'h0;
        {watchdog_reset, protected_write_enable, ratio_write, status_write} = 4'h0;
        {pll_disable_wdata, missing_clock_clear, osc_on, ext_on} = 4'h0;
        external_reset_pin_n = 1'b1;
        ratio_wdata = 4'h0;
        post_divider_select_wdata = 2'h0;
        bad_count = 0;
        num_checks = 0;
        repeat (5) @(negedge clk);
        resetn = 1'b1;
        repeat (4) @(negedge clk);
        check_val("ratio reset", 4'h0, pll_ratio_reg);
        check_val("divider reset", 4'h4, {1'b0, cpu_clock_divider});
        check_val("mode reset", {2'h0, MODE_BYPASS}, {2'h0, clock_mode});
        check_bit("wd count before osc", 1'b0, watchdog_count_enable);
        check_bit("no limp before osc", 1'b0, limp_active);
        osc_on = 1'b1;
        repeat (10) @(negedge clk);
        t_refused();
        t_post_divider_select_bypass();
        t_ratio_lock();
        t_pll_off();
        t_restores();
        t_ext_source();
        t_missing();
        tally_and_finish();
    end
endmodule : testbench
